// ==== core/cmo_ctrl.sv ====
`timescale 1ns/1ps
`include "cmo_consts.svh"

// Function
// - Configuration field picks role: off, transmit, receive, buffered receive.
// - Reply-valid bit marks an automatic reply ready after a remote frame.
// - Extension bit picks standard 11-bit or extended 29-bit identifier format.
// - A received frame overwrites the object's data length code unless a control write comes in the same cycle.
// - Received length differing from programmed one sets the mismatch warning.
// - Successful transmission sets the object's transmit-complete flag.
// - Among pending transmit objects the lowest index goes first.
// - Successful reception sets the object's receive-complete flag.
// - A frame hitting several receive objects updates only the lowest index.
// - Transmitter flags bit error on mismatch, except arbitration, ack, error frame.
// - More than five equal consecutive bits flags a stuffing error.
// - CRC over destuffed frame mismatching received CRC flags a CRC error.
// - Illegal bit in CRC delimiter, ack delimiter or end of frame flags form error.
// - No dominant bit in own acknowledge slot flags acknowledge error.
// - Each completion and error flag can raise an interrupt request.
// - Standard format: first tag register holds identifier bits 10 to 3.
// - Standard format: second tag holds bits 2 to 0 high; third tag reserved.
// - Standard format: fourth tag holds remote-request bit 2, reserved-bit-0 bit 0.
// - Extended format: first tag register holds identifier bits 28 to 21.
// - Reserved tag bits read zero in standard format; software never writes them as one.
// - Tag registers have no reset value and keep content until written.
// - Page object number selects object zero to fourteen for the object registers.
module cmo_ctrl
  import cmo_pkg::*;
#(
  parameter int N_OBJ = `CMO_NUM_OBJ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Special function register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  // Frame results from the protocol engine
  input wire logic rx_done,
  input wire logic [N_OBJ-1:0] rx_hit,
  input wire logic [3:0] rx_dlc,
  input wire logic rx_rtr,
  input wire logic tx_done,
  input wire logic [3:0] cur_obj,
  // Bit stream for error checks
  input wire logic bit_valid,
  input wire logic rx_bit,
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic frame_start,
  input wire logic in_arb,
  input wire logic in_ack_slot,
  input wire logic in_err_frame,
  input wire logic in_stuffed,
  input wire logic stuff_bit,
  input wire logic in_crc_calc,
  input wire logic in_crc_field,
  input wire logic crc_last,
  input wire logic in_fixed_form,
  // Transmit request toward the protocol engine
  output logic tx_pending_q,
  output logic [3:0] tx_obj_q,
  output logic tx_ide_q,
  output logic [28:0] tx_id_q,
  output logic tx_rtr_q,
  output logic [3:0] tx_dlc_q,
  // Object enables and interrupt request
  output logic [N_OBJ-1:0] obj_enable_q,
  output logic irq_req_q
);

  logic [7:0] page_q;
  logic [7:0] ctrl_q [N_OBJ];
  logic [7:0] st_q [N_OBJ];
  logic [7:0] tag_q [N_OBJ][4];
  logic [3:0] sel;
  logic sel_ok;
  logic [N_OBJ-1:0] rx_elig;
  logic [N_OBJ-1:0] rx_upd;
  logic [N_OBJ-1:0] tx_cand;
  logic [N_OBJ-1:0] wr_ctrl;
  logic [N_OBJ-1:0] wr_st;
  logic [N_OBJ-1:0] any_flag;
  logic [3:0] tx_low;
  logic tx_any;
  logic bit_err;
  logic stuff_err;
  logic crc_err;
  logic form_err;
  logic ack_err;
  logic [7:0] rd_d;
  logic [7:0] std_mask;

  // ----------------------------------------
  // Page selection
  // ----------------------------------------
  assign sel = page_q[`CMO_PAGE_OBJ_HI:`CMO_PAGE_OBJ_LO];
  assign sel_ok = (32'(sel) < N_OBJ);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      page_q <= `CMO_PAGE_RESET;
    end else if (sfr_wr && sfr_addr == `CMO_ADDR_PAGE) begin
      page_q <= sfr_wdata;
    end
  end

  // ----------------------------------------
  // Error detection
  // ----------------------------------------
  cmo_err_check u_err (
    .ref_clk(ref_clk),
    .reset(reset),
    .bit_valid(bit_valid),
    .rx_bit(rx_bit),
    .tx_bit(tx_bit),
    .tx_active(tx_active),
    .frame_start(frame_start),
    .in_arb(in_arb),
    .in_ack_slot(in_ack_slot),
    .in_err_frame(in_err_frame),
    .in_stuffed(in_stuffed),
    .stuff_bit(stuff_bit),
    .in_crc_calc(in_crc_calc),
    .in_crc_field(in_crc_field),
    .crc_last(crc_last),
    .in_fixed_form(in_fixed_form),
    .bit_err_q(bit_err),
    .stuff_err_q(stuff_err),
    .crc_err_q(crc_err),
    .form_err_q(form_err),
    .ack_err_q(ack_err)
  );

  // ----------------------------------------
  // Receive winner: lowest hit index
  // ----------------------------------------
  always_comb begin
    rx_upd = '0;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (rx_done && rx_elig[i] && rx_hit[i]) begin
        rx_upd = '0;
        rx_upd[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmit choice: lowest pending index
  // ----------------------------------------
  always_comb begin
    tx_low = 4'h0;
    tx_any = 1'b0;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (tx_cand[i]) begin
        tx_low = 4'(i);
        tx_any = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Per-object control, status and tags
  // ----------------------------------------
  for (genvar g = 0; g < N_OBJ; g++) begin : obj
    cmo_cfg_t cfg;
    logic [7:0] set_bits;
    logic own_err;
    logic tx_fin;

    assign cfg = cmo_cfg_t'(ctrl_q[g][`CMO_CFG_HI:`CMO_CFG_LO]);
    assign wr_ctrl[g] = sfr_wr && sel_ok && sfr_addr == `CMO_ADDR_CTRL && sel == 4'(g);
    assign wr_st[g] = sfr_wr && sel_ok && sfr_addr == `CMO_ADDR_STATUS && sel == 4'(g);
    assign rx_elig[g] = obj_enable_q[g] && (cfg == CMO_CFG_RX || cfg == CMO_CFG_RXBUF);
    assign tx_cand[g] = obj_enable_q[g] && cfg == CMO_CFG_TX;
    assign tx_fin = tx_done && tx_pending_q && tx_obj_q == 4'(g);
    assign own_err = cur_obj == 4'(g);
    assign any_flag[g] = |st_q[g];

    always_comb begin
      set_bits = 8'h00;
      set_bits[`CMO_LENGTH_MISMATCH_WARNING_BIT] = rx_upd[g] && rx_dlc != ctrl_q[g][`CMO_DLC_HI:0];
      set_bits[`CMO_TRANSMIT_COMPLETE_FLAG_BIT] = tx_fin;
      set_bits[`CMO_RECEIVE_COMPLETE_FLAG_BIT] = rx_upd[g];
      set_bits[`CMO_BIT_ERROR_FLAG_BIT] = own_err && bit_err;
      set_bits[`CMO_STUFFING_ERROR_FLAG_BIT] = own_err && stuff_err;
      set_bits[`CMO_CRC_ERROR_FLAG_BIT] = own_err && crc_err;
      set_bits[`CMO_FORM_ERROR_FLAG_BIT] = own_err && form_err;
      set_bits[`CMO_ACK_ERROR_FLAG_BIT] = own_err && ack_err;
    end

    // Control byte: software writes, received length, auto reply
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        ctrl_q[g] <= `CMO_CTRL_RESET;
      end else if (wr_ctrl[g]) begin
        ctrl_q[g] <= sfr_wdata;
      end else if (rx_upd[g]) begin
        ctrl_q[g][`CMO_DLC_HI:0] <= rx_dlc;
        if (rx_rtr && ctrl_q[g][`CMO_REPLY_VALID_BIT]) begin
          ctrl_q[g][`CMO_CFG_HI:`CMO_CFG_LO] <= CMO_CFG_TX;
          ctrl_q[g][`CMO_REPLY_VALID_BIT] <= 1'b0;
        end
      end
    end

    // Enable bit follows a configuration write
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        obj_enable_q[g] <= 1'b0;
      end else if (wr_ctrl[g]) begin
        obj_enable_q[g] <= sfr_wdata[`CMO_CFG_HI:`CMO_CFG_LO] != CMO_CFG_OFF;
      end else if (tx_fin) begin
        obj_enable_q[g] <= 1'b0;
      end else if (rx_upd[g] && cfg == CMO_CFG_RX) begin
        obj_enable_q[g] <= rx_rtr && ctrl_q[g][`CMO_REPLY_VALID_BIT];
      end
    end

    // Sticky status: write zero clears, new event wins
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        st_q[g] <= `CMO_STATUS_RESET;
      end else begin
        st_q[g] <= (wr_st[g] ? (st_q[g] & sfr_wdata) : st_q[g]) | set_bits;
      end
    end

    // Identifier tags: no reset
    always_ff @(posedge ref_clk) begin
      for (int k = 0; k < 4; k++) begin
        if (sfr_wr && sel_ok && sel == 4'(g) && sfr_addr == `CMO_ADDR_IDT1 + 8'(k)) begin
          tag_q[g][k] <= sfr_wdata;
        end
      end
    end

    dlc_overwrite_a: assert property (@(posedge ref_clk) disable iff (reset)
      (rx_upd[g] && !wr_ctrl[g]) |=> ctrl_q[g][`CMO_DLC_HI:0] == $past(rx_dlc))
      else $error("received length not stored");

    length_mismatch_warning_set_a: assert property (@(posedge ref_clk) disable iff (reset)
      (rx_upd[g] && rx_dlc != ctrl_q[g][`CMO_DLC_HI:0]) |=> st_q[g][`CMO_LENGTH_MISMATCH_WARNING_BIT])
      else $error("length mismatch not flagged");

    transmit_complete_flag_set_a: assert property (@(posedge ref_clk) disable iff (reset)
      tx_fin |=> st_q[g][`CMO_TRANSMIT_COMPLETE_FLAG_BIT] && (!obj_enable_q[g] || $past(wr_ctrl[g])))
      else $error("transmit completion not flagged");

    receive_complete_flag_set_a: assert property (@(posedge ref_clk) disable iff (reset)
      rx_upd[g] |=> st_q[g][`CMO_RECEIVE_COMPLETE_FLAG_BIT])
      else $error("receive completion not flagged");

    flag_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
      !wr_st[g] |=> (st_q[g] & $past(st_q[g])) == $past(st_q[g]))
      else $error("status flag cleared without write");

    enable_write_a: assert property (@(posedge ref_clk) disable iff (reset)
      (wr_ctrl[g] && sfr_wdata[`CMO_CFG_HI:`CMO_CFG_LO] != 2'h0) |=> obj_enable_q[g])
      else $error("configuration write did not enable object");
  end

  // ----------------------------------------
  // Transmit request toward the engine
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_pending_q <= 1'b0;
      tx_obj_q <= 4'h0;
      tx_ide_q <= 1'b0;
      tx_id_q <= 29'h0000000;
      tx_rtr_q <= 1'b0;
      tx_dlc_q <= 4'h0;
    end else begin
      tx_pending_q <= tx_any && !tx_done;
      tx_obj_q <= tx_low;
      tx_ide_q <= ctrl_q[tx_low][`CMO_IDE_BIT];
      tx_dlc_q <= ctrl_q[tx_low][`CMO_DLC_HI:0];
      tx_rtr_q <= tag_q[tx_low][3][2];
      if (ctrl_q[tx_low][`CMO_IDE_BIT]) begin
        tx_id_q <= {tag_q[tx_low][0], tag_q[tx_low][1], tag_q[tx_low][2], tag_q[tx_low][3][7:3]};
      end else begin
        tx_id_q <= {18'h00000, tag_q[tx_low][0], tag_q[tx_low][1][7:5]};
      end
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= |any_flag;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb begin
    std_mask = 8'hff;
    unique case (sfr_addr)
      `CMO_ADDR_IDT2: std_mask = `CMO_STD_IDT2_MASK;
      `CMO_ADDR_IDT3: std_mask = `CMO_STD_IDT3_MASK;
      `CMO_ADDR_IDT4: std_mask = `CMO_STD_IDT4_MASK;
      default: std_mask = 8'hff;
    endcase
    rd_d = 8'h00;
    if (sfr_addr == `CMO_ADDR_PAGE) begin
      rd_d = page_q;
    end else if (sel_ok) begin
      unique case (sfr_addr)
        `CMO_ADDR_CTRL: rd_d = ctrl_q[sel];
        `CMO_ADDR_STATUS: rd_d = st_q[sel];
        `CMO_ADDR_IDT1, `CMO_ADDR_IDT2, `CMO_ADDR_IDT3, `CMO_ADDR_IDT4: begin
          rd_d = tag_q[sel][sfr_addr[1:0]];
          if (!ctrl_q[sel][`CMO_IDE_BIT]) begin
            rd_d = rd_d & std_mask;
          end
        end
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rd_d;
    end
  end

  tx_lowest_a: assert property (@(posedge ref_clk) disable iff (reset)
    tx_pending_q |-> (($past(tx_cand) >> tx_obj_q) & 15'h0001) != '0
      && ($past(tx_cand) & ((15'h0001 << tx_obj_q) - 15'h0001)) == '0)
    else $error("transmit object not the lowest pending one");

  rx_lowest_a: assert property (@(posedge ref_clk) disable iff (reset)
    (rx_upd != '0) |-> $onehot(rx_upd) && ((rx_upd - 1'b1) & rx_elig & rx_hit) == '0)
    else $error("receive update not on lowest hit");

  std_tag4_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sfr_rd && sfr_addr == `CMO_ADDR_IDT4 && sel_ok && !ctrl_q[sel][`CMO_IDE_BIT])
      |=> (sfr_rdata_q & ~`CMO_STD_IDT4_MASK) == 8'h00)
    else $error("reserved standard tag bits read as one");

  irq_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    (|any_flag) |=> irq_req_q)
    else $error("set flag raised no interrupt request");

endmodule

// ==== core/cmo_err_check.sv ====
`timescale 1ns/1ps
`include "cmo_consts.svh"

module cmo_err_check
  import cmo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bit stream from the protocol engine
  input wire logic bit_valid,
  input wire logic rx_bit,
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic frame_start,
  // Frame field markers
  input wire logic in_arb,
  input wire logic in_ack_slot,
  input wire logic in_err_frame,
  input wire logic in_stuffed,
  input wire logic stuff_bit,
  input wire logic in_crc_calc,
  input wire logic in_crc_field,
  input wire logic crc_last,
  input wire logic in_fixed_form,
  // Error pulses
  output logic bit_err_q,
  output logic stuff_err_q,
  output logic crc_err_q,
  output logic form_err_q,
  output logic ack_err_q
);

  logic [2:0] run_cnt_q;
  logic last_bit_q;
  logic [14:0] crc_q;
  logic [14:0] rcv_q;
  logic fb;

  assign fb = rx_bit ^ crc_q[14];

  // ----------------------------------------
  // Bit, form and acknowledge errors
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_err_q <= 1'b0;
      form_err_q <= 1'b0;
      ack_err_q <= 1'b0;
    end else begin
      bit_err_q <= bit_valid && tx_active && (rx_bit != tx_bit)
                   && !(in_arb && tx_bit && !rx_bit)
                   && !(in_ack_slot && !rx_bit)
                   && !(in_err_frame && !rx_bit);
      form_err_q <= bit_valid && in_fixed_form && !rx_bit;
      ack_err_q <= bit_valid && tx_active && in_ack_slot && rx_bit;
    end
  end

  // ----------------------------------------
  // Stuffing check
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_cnt_q <= 3'h0;
      last_bit_q <= 1'b1;
      stuff_err_q <= 1'b0;
    end else begin
      stuff_err_q <= 1'b0;
      if (frame_start) begin
        run_cnt_q <= 3'h0;
        last_bit_q <= 1'b1;
      end else if (bit_valid && in_stuffed) begin
        last_bit_q <= rx_bit;
        if (rx_bit == last_bit_q && run_cnt_q != 3'h0) begin
          if (run_cnt_q >= `CMO_STUFF_LIMIT) begin
            stuff_err_q <= 1'b1;
          end else begin
            run_cnt_q <= run_cnt_q + 3'h1;
          end
        end else begin
          run_cnt_q <= 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // CRC over destuffed bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      crc_q <= `CMO_CRC_INIT;
      rcv_q <= `CMO_CRC_INIT;
      crc_err_q <= 1'b0;
    end else begin
      crc_err_q <= 1'b0;
      if (frame_start) begin
        crc_q <= `CMO_CRC_INIT;
        rcv_q <= `CMO_CRC_INIT;
      end else if (bit_valid && !stuff_bit) begin
        if (in_crc_calc) begin
          crc_q <= {crc_q[13:0], 1'b0} ^ (fb ? `CMO_CRC_POLY : 15'h0000);
        end
        if (in_crc_field) begin
          rcv_q <= {rcv_q[13:0], rx_bit};
          if (crc_last) begin
            crc_err_q <= ({rcv_q[13:0], rx_bit} != crc_q);
          end
        end
      end
    end
  end

  stuff_err_a: assert property (@(posedge ref_clk) disable iff (reset)
    stuff_err_q |-> $past(run_cnt_q) == `CMO_STUFF_LIMIT && $past(rx_bit) == $past(last_bit_q))
    else $error("stuffing error without six equal bits");

  ack_err_a: assert property (@(posedge ref_clk) disable iff (reset)
    (bit_valid && tx_active && in_ack_slot && rx_bit) |=> ack_err_q)
    else $error("recessive acknowledge slot not flagged");

endmodule

// ==== inc/cmo_consts.svh ====
`ifndef CMO_CONSTS_SVH
`define CMO_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CMO_ADDR_PAGE 8'hb1
`define CMO_ADDR_STATUS 8'hb2
`define CMO_ADDR_CTRL 8'hb3
`define CMO_ADDR_IDT1 8'hbc
`define CMO_ADDR_IDT2 8'hbd
`define CMO_ADDR_IDT3 8'hbe
`define CMO_ADDR_IDT4 8'hbf

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define CMO_NUM_OBJ 15
`define CMO_PAGE_RESET 8'h00
`define CMO_CTRL_RESET 8'h00
`define CMO_STATUS_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMO_PAGE_OBJ_HI 7
`define CMO_PAGE_OBJ_LO 4
`define CMO_CFG_HI 7
`define CMO_CFG_LO 6
`define CMO_REPLY_VALID_BIT 5
`define CMO_IDE_BIT 4
`define CMO_DLC_HI 3
`define CMO_LENGTH_MISMATCH_WARNING_BIT 7
`define CMO_TRANSMIT_COMPLETE_FLAG_BIT 6
`define CMO_RECEIVE_COMPLETE_FLAG_BIT 5
`define CMO_BIT_ERROR_FLAG_BIT 4
`define CMO_STUFFING_ERROR_FLAG_BIT 3
`define CMO_CRC_ERROR_FLAG_BIT 2
`define CMO_FORM_ERROR_FLAG_BIT 1
`define CMO_ACK_ERROR_FLAG_BIT 0

// ----------------------------------------
// Standard-format readable tag bits
// ----------------------------------------
`define CMO_STD_IDT2_MASK 8'he0
`define CMO_STD_IDT3_MASK 8'h00
`define CMO_STD_IDT4_MASK 8'h05

// ----------------------------------------
// Bus checks
// ----------------------------------------
`define CMO_STUFF_LIMIT 3'h5
`define CMO_CRC_POLY 15'h4599
`define CMO_CRC_INIT 15'h0000

`endif

// ==== inc/cmo_pkg.sv ====
package cmo_pkg;

  // Object role selected by the configuration field
  typedef enum logic [1:0] {
    CMO_CFG_OFF = 2'h0,
    CMO_CFG_TX = 2'h1,
    CMO_CFG_RX = 2'h2,
    CMO_CFG_RXBUF = 2'h3
  } cmo_cfg_t;

endpackage

// ==== tb/cmo_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "cmo_consts.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end

module cmo_ctrl_tb;
  import cmo_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata_q;
  logic rx_done, rx_rtr, tx_done, bit_valid, rx_bit, tx_bit, tx_active, frame_start;
  logic [14:0] rx_hit;
  logic [3:0] rx_dlc, cur_obj;
  logic [8:0] marks;
  logic tx_pending_q, tx_ide_q, tx_rtr_q, irq_req_q;
  logic [3:0] tx_obj_q, tx_dlc_q;
  logic [28:0] tx_id_q;
  logic [14:0] obj_enable_q;
  int err_count = 0;
  int n_tests = 0;
  logic [14:0] crc_ref = `CMO_CRC_POLY;

  always #4 ref_clk = ~ref_clk;

  cmo_engine_model #(.N_OBJ(15)) eng (.ref_clk(ref_clk), .rx_done(rx_done), .rx_hit(rx_hit), .rx_dlc(rx_dlc),
    .rx_rtr(rx_rtr), .tx_done(tx_done), .cur_obj(cur_obj), .bit_valid(bit_valid), .rx_bit(rx_bit),
    .tx_bit(tx_bit), .tx_active(tx_active), .frame_start(frame_start), .marks(marks));

  cmo_ctrl #(.N_OBJ(15)) DUT (.ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .rx_done(rx_done), .rx_hit(rx_hit),
    .rx_dlc(rx_dlc), .rx_rtr(rx_rtr), .tx_done(tx_done), .cur_obj(cur_obj), .bit_valid(bit_valid),
    .rx_bit(rx_bit), .tx_bit(tx_bit), .tx_active(tx_active), .frame_start(frame_start), .in_arb(marks[8]),
    .in_ack_slot(marks[7]), .in_err_frame(marks[6]), .in_stuffed(marks[5]), .stuff_bit(marks[4]),
    .in_crc_calc(marks[3]), .in_crc_field(marks[2]), .crc_last(marks[1]), .in_fixed_form(marks[0]),
    .tx_pending_q(tx_pending_q), .tx_obj_q(tx_obj_q), .tx_ide_q(tx_ide_q), .tx_id_q(tx_id_q),
    .tx_rtr_q(tx_rtr_q), .tx_dlc_q(tx_dlc_q), .obj_enable_q(obj_enable_q), .irq_req_q(irq_req_q));

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    `CHK(sfr_rdata_q, e)
  endtask

  // Config rewritten on every setup so the enable follows
  task automatic obj(input logic [3:0] o, input logic [7:0] ctl);
    wr(`CMO_ADDR_PAGE, {o, 4'h0});
    wr(`CMO_ADDR_CTRL, ctl);
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    close_out();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(`CMO_ADDR_PAGE, 8'h00);
    rd_chk(`CMO_ADDR_CTRL, 8'h00);
    rd_chk(`CMO_ADDR_STATUS, 8'h00);
    `CHK(obj_enable_q, 15'h0000)
    for (int i = 0; i < 4; i++) begin
      obj(4'h7, {2'(i), 6'h00});
      settle();
      `CHK(obj_enable_q[7], 1'(i != 0))
      `CHK(tx_pending_q, 1'(i == 1))
      rd_chk(`CMO_ADDR_CTRL, {2'(i), 6'h00});
    end
    obj(4'h7, 8'h00);
    obj(4'h5, 8'h42);
    obj(4'h2, 8'h41);
    settle();
    `CHK(tx_obj_q, 4'h2)
    `CHK(tx_dlc_q, 4'h1)
    eng.tx_finish();
    settle();
    `CHK(irq_req_q, 1'b1)
    `CHK(tx_obj_q, 4'h5)
    rd_chk(`CMO_ADDR_STATUS, 8'h40);
    settle();
    rd_chk(`CMO_ADDR_STATUS, 8'h40);
    wr(`CMO_ADDR_STATUS, 8'h00);
    rd_chk(`CMO_ADDR_STATUS, 8'h00);
    settle();
    `CHK(irq_req_q, 1'b0)
    obj(4'h5, 8'h00);
    settle();
    `CHK(tx_pending_q, 1'b0)
    obj(4'h1, 8'h88);
    obj(4'h3, 8'h88);
    eng.rx_frame(15'h000a, 4'h4, 1'b0);
    wr(`CMO_ADDR_PAGE, 8'h10);
    rd_chk(`CMO_ADDR_CTRL, 8'h84);
    rd_chk(`CMO_ADDR_STATUS, 8'ha0);
    wr(`CMO_ADDR_PAGE, 8'h30);
    rd_chk(`CMO_ADDR_STATUS, 8'h00);
    obj(4'h3, 8'hc8);
    eng.rx_frame(15'h0008, 4'h8, 1'b0);
    settle();
    `CHK(obj_enable_q[3], 1'b1)
    `CHK(obj_enable_q[1], 1'b0)
    rd_chk(`CMO_ADDR_STATUS, 8'h20);
    obj(4'h6, 8'ha3);
    eng.rx_frame(15'h0040, 4'h0, 1'b1);
    rd_chk(`CMO_ADDR_CTRL, 8'h40);
    `CHK(obj_enable_q[6], 1'b1)
    `CHK(tx_obj_q, 4'h6)
    obj(4'h0, 8'h00);
    wr(`CMO_ADDR_IDT1, 8'ha5);
    wr(`CMO_ADDR_IDT2, 8'hc0);
    wr(`CMO_ADDR_IDT4, 8'h04);
    rd_chk(`CMO_ADDR_IDT1, 8'ha5);
    rd_chk(`CMO_ADDR_IDT2, 8'hc0);
    rd_chk(`CMO_ADDR_IDT3, 8'h00);
    rd_chk(`CMO_ADDR_IDT4, 8'h04);
    obj(4'h0, 8'h10);
    wr(`CMO_ADDR_IDT1, 8'h3c);
    wr(`CMO_ADDR_IDT2, 8'h5a);
    rd_chk(`CMO_ADDR_IDT1, 8'h3c);
    rd_chk(`CMO_ADDR_IDT2, 8'h5a);
    wr(`CMO_ADDR_IDT3, 8'h12);
    wr(`CMO_ADDR_IDT4, 8'h3c);
    obj(4'h0, 8'h50);
    settle();
    `CHK(tx_obj_q, 4'h0)
    `CHK(tx_ide_q, 1'b1)
    `CHK(tx_id_q, {8'h3c, 8'h5a, 8'h12, 5'h07})
    `CHK(tx_rtr_q, 1'b1)
    obj(4'h0, 8'h41);
    settle();
    `CHK(tx_ide_q, 1'b0)
    `CHK(tx_id_q, {18'h00000, 8'h3c, 3'h2})
    obj(4'hf, 8'h40);
    rd_chk(`CMO_ADDR_CTRL, 8'h00);
    wr(`CMO_ADDR_PAGE, 8'h40);
    eng.set_obj(4'h4);
    eng.send_bit(1'b0, 1'b1, 1'b1, 9'h100);
    rd_chk(`CMO_ADDR_STATUS, 8'h00);
    eng.send_bit(1'b0, 1'b1, 1'b1, 9'h000);
    rd_chk(`CMO_ADDR_STATUS, 8'h10);
    eng.send_bit(1'b0, 1'b0, 1'b0, 9'h001);
    rd_chk(`CMO_ADDR_STATUS, 8'h12);
    eng.send_bit(1'b1, 1'b1, 1'b1, 9'h080);
    rd_chk(`CMO_ADDR_STATUS, 8'h13);
    eng.start_frame();
    repeat (5) eng.send_bit(1'b1, 1'b1, 1'b0, 9'h020);
    rd_chk(`CMO_ADDR_STATUS, 8'h13);
    eng.send_bit(1'b1, 1'b1, 1'b0, 9'h020);
    rd_chk(`CMO_ADDR_STATUS, 8'h1b);
    for (int k = 0; k < 2; k++) begin
      eng.start_frame();
      eng.send_bit(1'b1, 1'b1, 1'b0, 9'h008);
      for (int b = 14; b >= 0; b--) begin
        eng.send_bit(crc_ref[b] ^ (b == 0 && k == 1), 1'b1, 1'b0, (b == 0) ? 9'h006 : 9'h004);
      end
      rd_chk(`CMO_ADDR_STATUS, (k == 1) ? 8'h1f : 8'h1b);
    end
    wr(`CMO_ADDR_STATUS, 8'h00);
    eng.send_bit(1'b0, 1'b1, 1'b1, 9'h080);
    eng.send_bit(1'b0, 1'b1, 1'b1, 9'h040);
    rd_chk(`CMO_ADDR_STATUS, 8'h00);
    close_out();
  end
endmodule

// ==== tb/cmo_engine_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Protocol engine and bus side stand-in
// ----------------------------------------
module cmo_engine_model #(
  parameter int N_OBJ = 15
) (
  // Clock
  input wire logic ref_clk,
  // Frame results
  output logic rx_done,
  output logic [N_OBJ-1:0] rx_hit,
  output logic [3:0] rx_dlc,
  output logic rx_rtr,
  output logic tx_done,
  output logic [3:0] cur_obj,
  // Bit stream and field markers
  output logic bit_valid,
  output logic rx_bit,
  output logic tx_bit,
  output logic tx_active,
  output logic frame_start,
  output logic [8:0] marks
);
  initial begin
    {rx_done, rx_rtr, tx_done, bit_valid, tx_active, frame_start} = '0;
    rx_hit = '0;
    rx_dlc = 4'h0;
    cur_obj = 4'h0;
    rx_bit = 1'b1;
    tx_bit = 1'b1;
    marks = '0;
  end

  // Released length and remote-request lines show the inverse of the last value; hit lines clear
  task automatic rx_frame(input logic [N_OBJ-1:0] hit, input logic [3:0] dlc, input logic rtr);
    @(posedge ref_clk);
    rx_done <= 1'b1;
    rx_hit <= hit;
    rx_dlc <= dlc;
    rx_rtr <= rtr;
    @(posedge ref_clk);
    rx_done <= 1'b0;
    rx_hit <= '0;
    rx_dlc <= ~dlc;
    rx_rtr <= ~rtr;
  endtask

  task automatic tx_finish();
    @(posedge ref_clk);
    tx_done <= 1'b1;
    @(posedge ref_clk);
    tx_done <= 1'b0;
  endtask

  task automatic set_obj(input logic [3:0] o);
    @(posedge ref_clk);
    cur_obj <= o;
  endtask

  task automatic start_frame();
    @(posedge ref_clk);
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
  endtask

  // Idle bus rests recessive between bits
  task automatic send_bit(input logic rx, input logic tx, input logic act, input logic [8:0] mk);
    @(posedge ref_clk);
    bit_valid <= 1'b1;
    rx_bit <= rx;
    tx_bit <= tx;
    tx_active <= act;
    marks <= mk;
    @(posedge ref_clk);
    bit_valid <= 1'b0;
    rx_bit <= 1'b1;
    tx_active <= 1'b0;
    marks <= '0;
  endtask
endmodule
